// file: dv/switch_node_config_regs_assertions.sv
// concurrent checks on the config bank ports
`timescale 1ns/100ps
module switch_node_config_regs_checker
    import switch_node_cfg_pkg::*;
(
    // clock, reset and requests
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst,
    input  wire logic       i_cfg_wr_req,
    input  wire logic       i_cfg_rd_req,
    input  wire logic [7:0] i_cfg_reg_num,
    input  wire logic       i_route_req,
    input  wire logic       i_core_in_debug,
    // answers
    input  wire logic       o_cfg_wr_done,
    input  wire logic       o_cfg_wr_refused,
    input  wire logic       o_cfg_rd_done,
    input  wire logic       o_tile_reset,
    input  wire logic       o_route_valid,
    input  wire logic       o_route_local,
    input  wire logic [3:0] o_route_direction,
    input  wire logic       o_debug_line_out,
    input  wire logic       o_debug_line_oe
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    sequence s_pll_wr;
        i_cfg_wr_req && i_cfg_reg_num == REG_PLL;
    endsequence
    a_wr_answered: assert property (i_cfg_wr_req |=> o_cfg_wr_done)
        else $error("write not answered");
    a_rd_answered: assert property (i_cfg_rd_req |=> o_cfg_rd_done)
        else $error("read not answered");
    a_done_has_cause: assert property (o_cfg_wr_done |-> $past(i_cfg_wr_req))
        else $error("write done without request");
    a_refusal_pairs: assert property (o_cfg_wr_refused |-> o_cfg_wr_done)
        else $error("refusal outside a write answer");
    a_pll_write_resets: assert property (s_pll_wr ##1 !o_cfg_wr_refused |-> o_tile_reset)
        else $error("accepted pll write gave no tile reset");
    a_reset_has_cause: assert property (o_tile_reset |-> !o_cfg_wr_refused
        && $past(i_cfg_wr_req) && $past(i_cfg_reg_num) == REG_PLL)
        else $error("tile reset without accepted pll write");
    a_route_answered: assert property (i_route_req |=> o_route_valid)
        else $error("route lookup not answered");
    a_local_no_dir: assert property (o_route_valid && o_route_local
        |-> o_route_direction == 4'h0)
        else $error("local delivery carried a direction");
    a_line_pulls_low: assert property (o_debug_line_oe |-> !o_debug_line_out)
        else $error("debug line driven high");
    a_pull_needs_debug: assert property (o_debug_line_oe |-> $past(i_core_in_debug))
        else $error("debug line pulled outside debug mode");
endmodule : switch_node_config_regs_checker

bind switch_node_config_regs switch_node_config_regs_checker u_chk (.i_ref_clk, .i_rst,
    .i_cfg_wr_req, .i_cfg_rd_req, .i_cfg_reg_num, .i_route_req, .i_core_in_debug, .o_cfg_wr_done,
    .o_cfg_wr_refused, .o_cfg_rd_done, .o_tile_reset, .o_route_valid, .o_route_local,
    .o_route_direction, .o_debug_line_out, .o_debug_line_oe);

// file: dv/switch_node_config_regs_tb.sv
// self-checking bench for the config register bank
`timescale 1ns/100ps
module switch_node_config_regs_tb;
    import switch_node_cfg_pkg::*;
    logic        i_ref_clk, i_rst, wr, rd, rq, pa, pb, dl, cid, tde, stk;
    logic [2:0]  pod;
    logic [12:0] pfm;
    logic [6:0]  pid;
    logic        wdn, wrf, rdn, rv, rl, obh, trst, rtk, doo, doe, core_debug_call;
    logic [7:0]  rn;
    logic [3:0]  dir;
    logic [15:0] dst, na, oad;
    logic [31:0] wd, rdata, st, lo, hi;
    logic [7:0]  zregs [7] = '{REG_LOCK_HDR, REG_NODE_ADDR, REG_SWITCH_RATIO, REG_ROUTE_LOW,
                               REG_ROUTE_HIGH, REG_DEBUG_LINE, 8'h02};
    int          failures, n_checks, k, m;
    switch_node_config_regs dut (
        .i_ref_clk, .i_rst, .i_cfg_wr_req(wr), .i_cfg_rd_req(rd), .i_cfg_reg_num(rn),
        .i_cfg_wdata(wd), .o_cfg_wr_done(wdn), .o_cfg_wr_refused(wrf), .o_cfg_rd_done(rdn),
        .o_cfg_rdata(rdata), .i_boot_select_pin_a(pa), .i_boot_select_pin_b(pb),
        .i_route_req(rq), .i_route_dest(dst), .o_route_valid(rv), .o_route_local(rl),
        .o_route_direction(dir), .o_one_byte_header(obh), .o_node_addr(oad),
        .o_pll_output_divider(pod), .o_pll_feedback_mult(pfm), .o_pll_input_divider(pid),
        .o_tile_reset(trst), .o_switch_clk_tick(stk), .o_ref_clk_tick(rtk),
        .i_debug_line(dl), .o_debug_line_out(doo), .o_debug_line_oe(doe),
        .i_core_in_debug(cid), .i_tile_debug_event(tde), .o_core_debug_call(core_debug_call));
    function automatic logic [31:0] xs();
        st = st ^ (st << 13);
        st = st ^ (st >> 17);
        st = st ^ (st << 5);
        return st;
    endfunction : xs
    // highest differing bit wins, so scan upward and keep the last hit
    function automatic logic [3:0] exp_dir(input logic [15:0] d);
        logic [63:0] t;
        t = {hi, lo};
        exp_dir = 4'h0;
        for (int b = 0; b < 16; b++)
            if (d[b] != na[b])
                exp_dir = t[4*b +: 4];
    endfunction : exp_dir
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e)
        begin
            failures++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wrr(input logic [7:0] r, input logic [31:0] d, input logic f);
        @(posedge i_ref_clk) #1;
        {wr, rn, wd} = {1'b1, r, d};
        @(posedge i_ref_clk) #1;
        wr = 0;
        chk("wr_done", 32'(wdn), 32'h1);
        chk("refused", 32'(wrf), 32'(f));
    endtask : wrr
    task automatic rdc(input logic [7:0] r, input logic [31:0] e);
        @(posedge i_ref_clk) #1;
        {rd, rn} = {1'b1, r};
        @(posedge i_ref_clk) #1;
        rd = 0;
        chk($sformatf("reg %h", r), rdn ? rdata : 32'hx, e);
    endtask : rdc
    task automatic rte(input logic [15:0] d);
        @(posedge i_ref_clk) #1;
        {rq, dst} = {1'b1, d};
        @(posedge i_ref_clk) #1;
        rq = 0;
        chk("local", 32'(rl & rv), 32'(d == na));
        chk("dir", 32'(dir), 32'(exp_dir(d)));
    endtask : rte
    task automatic report_and_stop();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    initial
    begin
        i_ref_clk = 0;
        forever #10 i_ref_clk = ~i_ref_clk;
    end
    initial
    begin
        #200000;
        failures++;
        report_and_stop();
    end
    initial
    begin
        {i_rst, wr, rd, rq, pa, pb, dl, cid, tde} = 9'b1000_1010_0;
        {rn, wd, dst, na, lo, hi, st} = {8'h0, 32'h0, 16'h0, 16'h0, 64'h0, 32'd12};
        repeat (8) @(posedge i_ref_clk);
        #1 i_rst = 0;
        rdc(REG_IDENT, 32'h5a010101);
        rdc(REG_DESCR, 32'h00080104);
        rdc(REG_PLL, PLL_RESET_BOOT_SELECT_PIN_B);
        chk("pll fields", 32'({pod, 2'h0, pfm, 1'h0, pid}), PLL_RESET_BOOT_SELECT_PIN_B);
        rdc(REG_REF_RATIO, 32'h3);
        foreach (zregs[i])
            rdc(zregs[i], 32'h0);
        k = 0;
        repeat (40)
        begin
            @(posedge i_ref_clk) #1 k += rtk;
            m += stk;
        end
        chk("ref ticks", k, 10);
        chk("switch ticks", m, 40);
        wrr(REG_NODE_ADDR, 32'hffffffff, 0);
        rdc(REG_NODE_ADDR, 32'h0000ffff);
        chk("node addr", 32'(oad), 32'h0000ffff);
        wrr(REG_PLL, 32'hffffffff, 0);
        chk("tile reset", 32'(trst), 32'h1);
        rdc(REG_PLL, PLL_WRITE_MASK);
        chk("pll fields", 32'({pod, 2'h0, pfm, 1'h0, pid}), PLL_WRITE_MASK);
        wrr(REG_LOCK_HDR, 32'h1, 0);
        chk("header", 32'(obh), 32'h1);
        wrr(REG_DEBUG_LINE, 32'h3, 0);
        dl = 0;
        k = 0;
        repeat (8) @(posedge i_ref_clk) #1 k += core_debug_call;
        chk("debug calls", k, 1);
        rdc(REG_DEBUG_ORIGIN, 32'h10);
        tde = 1;
        @(posedge i_ref_clk) #1 tde = 0;
        rdc(REG_DEBUG_ORIGIN, 32'h1);
        {dl, cid} = 2'b11;
        repeat (3) @(posedge i_ref_clk);
        #1 chk("line pull", 32'(doe), 32'h1);
        chk("line out", 32'(doo), 32'h0);
        cid = 0;
        {na, lo, hi} = {16'(xs()), xs(), xs()};
        wrr(REG_NODE_ADDR, {16'h0, na}, 0);
        wrr(REG_ROUTE_LOW, lo, 0);
        wrr(REG_ROUTE_HIGH, hi, 0);
        rte(na);
        for (k = 0; k < 16; k++) rte(na ^ (16'h1 << k));
        repeat (40) rte(16'(xs()));
        wrr(REG_LOCK_HDR, 32'h101, 0);
        wrr(REG_PLL, 32'h0, 1);
        chk("tile reset", 32'(trst), 32'h0);
        rdc(REG_PLL, PLL_WRITE_MASK);
        wrr(REG_LOCK_HDR, 32'h80000101, 0);
        wrr(REG_NODE_ADDR, 32'h0, 1);
        rdc(REG_NODE_ADDR, {16'h0, na});
        wrr(REG_LOCK_HDR, 32'h0, 1);
        rdc(REG_LOCK_HDR, 32'h80000101);
        report_and_stop();
    end
endmodule : switch_node_config_regs_tb

// file: rtl/ratio_tick_divider.sv
// programmable divider: one tick every (ratio + 1) clock cycles
`timescale 1ns/100ps
module ratio_tick_divider #(
    parameter int RATIO_W = 16
) (
    // clock and reset
    input  wire logic               i_ref_clk,
    input  wire logic               i_rst,
    // ratio
    input  wire logic [RATIO_W-1:0] i_ratio,
    // tick out
    output logic                    o_tick
);

    logic [RATIO_W-1:0] count;
    wire                wrap = (count >= i_ratio);

    // a lowered ratio takes effect at once, the counter never overshoots
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            count  <= '0;
            o_tick <= 1'b0;
        end
        else
        begin
            count  <= wrap ? '0 : count + 1'b1;
            o_tick <= wrap;
        end
    end

endmodule : ratio_tick_divider

// file: rtl/switch_node_cfg_pkg.sv
// constants for the switching-node configuration register bank
package switch_node_cfg_pkg;

    // register numbers used by configuration reads and writes
    localparam int              REG_NUM_W        = 8;
    localparam int              DATA_W           = 32;
    localparam logic [7:0]      REG_IDENT        = 8'h00;
    localparam logic [7:0]      REG_DESCR        = 8'h01;
    localparam logic [7:0]      REG_LOCK_HDR     = 8'h04;
    localparam logic [7:0]      REG_NODE_ADDR    = 8'h05;
    localparam logic [7:0]      REG_PLL          = 8'h06;
    localparam logic [7:0]      REG_SWITCH_RATIO = 8'h07;
    localparam logic [7:0]      REG_REF_RATIO    = 8'h08;
    localparam logic [7:0]      REG_ROUTE_LOW    = 8'h0c;
    localparam logic [7:0]      REG_ROUTE_HIGH   = 8'h0d;
    localparam logic [7:0]      REG_DEBUG_LINE   = 8'h10;
    localparam logic [7:0]      REG_DEBUG_ORIGIN = 8'h1f;

    // identification and description field positions
    localparam int              ID_CHIP_LSB      = 24;
    localparam int              ID_MODE_LSB      = 16;
    localparam int              ID_REV_LSB       = 8;
    localparam int              ID_VER_LSB       = 0;
    localparam int              DESCR_LINKS_LSB  = 16;
    localparam int              DESCR_CORES_LSB  = 8;
    localparam int              DESCR_LPP_LSB    = 0;

    // lock and header-mode bits
    localparam int              LOCK_WRITE_BIT   = 31;
    localparam int              LOCK_PLL_BIT     = 8;
    localparam int              HEADER_MODE_BIT  = 0;

    // node address and direction tables
    localparam int              NODE_ADDR_W      = 16;
    localparam int              DIR_W            = 4;
    localparam int              DIR_IDX_W        = 4;

    // pll field layout
    localparam int              PLL_OD_LSB       = 23;
    localparam int              PLL_OD_W         = 3;
    localparam int              PLL_F_LSB        = 8;
    localparam int              PLL_F_W          = 13;
    localparam int              PLL_R_LSB        = 0;
    localparam int              PLL_R_W          = 7;
    localparam logic [31:0]     PLL_WRITE_MASK   = 32'h039fff7f;

    // clock ratio fields
    localparam int              RATIO_W          = 16;

    // debug line control and origin bits
    localparam int              DBG_CALL_EN_BIT  = 1;
    localparam int              DBG_PULL_EN_BIT  = 0;
    localparam int              ORIGIN_PIN_BIT   = 4;
    localparam int              ORIGIN_TILE_BIT  = 0;

    // reset values
    localparam logic [31:0]     LOCK_HDR_RESET     = 32'h00000000;
    localparam logic [15:0]     NODE_ADDR_RESET    = 16'h0000;
    localparam logic [15:0]     SWITCH_RATIO_RESET = 16'h0000;
    localparam logic [15:0]     REF_RATIO_RESET    = 16'h0003;
    localparam logic [31:0]     ROUTE_RESET        = 32'h00000000;
    localparam logic [1:0]      DEBUG_LINE_RESET   = 2'h0;
    localparam logic [1:0]      ORIGIN_RESET       = 2'h0;
    localparam logic [1:0]      BOOT_MODE_RESET    = 2'h0;

    // pll start values chosen by the sampled boot-select pins {b, a}
    localparam logic [31:0]     PLL_RESET_BOOT_SELECT_PIN_A  = 32'h00801003;
    localparam logic [31:0]     PLL_RESET_BOOT_SELECT_PIN_B  = 32'h00802003;
    localparam logic [31:0]     PLL_RESET_MODE2  = 32'h01001003;
    localparam logic [31:0]     PLL_RESET_MODE3  = 32'h01002003;

endpackage : switch_node_cfg_pkg

// file: rtl/switch_node_config_regs.sv
// configuration register bank of a packet-switching node
//
// Functional notes
// - registers are read and written by register number over the config port
// - identification: chip id, sampled boot pins, revision, version
// - description: read-only link count, core count, links per processor
// - lock bit 31 refuses every config write; resets to zero
// - lock bit 8 blocks pll settings updates; resets to zero
// - header bit 0 selects one-byte headers; software sets it on all nodes
// - writable 16-bit node address, reset zero, compared msb first
// - mismatching destination routes by entry of highest differing bit
// - low table: eight nibbles, positions 7..0, bit 7 in 31:28
// - high table: eight nibbles, positions 15..8, bit 15 in 31:28
// - accepted pll settings write pulses a tile reset
// - pll fields od, feedback, input divider; start values from boot pins
// - switch clock ratio is divider value plus one, resets zero
// - reference ratio is divider value plus one, resets to three
// - debug call enable lets debug line activity raise a core debug call
// - pull enable drives debug line low while in debug mode
`timescale 1ns/100ps
module switch_node_config_regs
    import switch_node_cfg_pkg::*;
#(
    parameter logic [7:0] CHIP_ID         = 8'h5a,  // arbitrary value
    parameter logic [7:0] REVISION        = 8'h01,  // arbitrary value
    parameter logic [7:0] VERSION         = 8'h01,  // arbitrary value
    parameter logic [7:0] LINK_COUNT      = 8'h08,
    parameter logic [7:0] CORE_COUNT      = 8'h01,
    parameter logic [7:0] LINKS_PER_CORE  = 8'h04
) (
    // clock and reset
    input  wire logic                          i_ref_clk,
    input  wire logic                          i_rst,
    // configuration read/write port
    input  wire logic                          i_cfg_wr_req,
    input  wire logic                          i_cfg_rd_req,
    input  wire logic [switch_node_cfg_pkg::REG_NUM_W-1:0] i_cfg_reg_num,
    input  wire logic [switch_node_cfg_pkg::DATA_W-1:0]    i_cfg_wdata,
    output logic                               o_cfg_wr_done,
    output logic                               o_cfg_wr_refused,
    output logic                               o_cfg_rd_done,
    output logic [switch_node_cfg_pkg::DATA_W-1:0]         o_cfg_rdata,
    // boot-select pins
    input  wire logic                          i_boot_select_pin_a,
    input  wire logic                          i_boot_select_pin_b,
    // routing lookup
    input  wire logic                          i_route_req,
    input  wire logic [switch_node_cfg_pkg::NODE_ADDR_W-1:0] i_route_dest,
    output logic                               o_route_valid,
    output logic                               o_route_local,
    output logic [switch_node_cfg_pkg::DIR_W-1:0]          o_route_direction,
    // node settings
    output logic                               o_one_byte_header,
    output logic [switch_node_cfg_pkg::NODE_ADDR_W-1:0]    o_node_addr,
    output logic [switch_node_cfg_pkg::PLL_OD_W-1:0]       o_pll_output_divider,
    output logic [switch_node_cfg_pkg::PLL_F_W-1:0]        o_pll_feedback_mult,
    output logic [switch_node_cfg_pkg::PLL_R_W-1:0]        o_pll_input_divider,
    output logic                               o_tile_reset,
    output logic                               o_switch_clk_tick,
    output logic                               o_ref_clk_tick,
    // debug request line (open drain) and core debug
    input  wire logic                          i_debug_line,
    output logic                               o_debug_line_out,
    output logic                               o_debug_line_oe,
    input  wire logic                          i_core_in_debug,
    input  wire logic                          i_tile_debug_event,
    output logic                               o_core_debug_call
);

    import switch_node_cfg_pkg::*;

    // register state
    logic                   write_lock;
    logic                   pll_lock;
    logic                   header_mode;
    logic [NODE_ADDR_W-1:0] node_addr;
    logic [31:0]            pll_settings;
    logic [RATIO_W-1:0]     switch_ratio;
    logic [RATIO_W-1:0]     ref_ratio;
    logic [31:0]            route_low;
    logic [31:0]            route_high;
    logic                   call_enable;
    logic                   pull_enable;
    logic                   origin_pin;
    logic                   origin_tile;

    // pin synchronisers and boot capture
    logic [1:0]             boot_meta;
    logic [1:0]             boot_sync;
    logic [1:0]             boot_mode;
    logic                   boot_captured;
    logic                   dbg_meta;
    logic                   dbg_sync;
    logic                   dbg_prev;

    // write decode
    wire wr_blocked   = i_cfg_wr_req && write_lock;
    wire wr_pll_block = i_cfg_wr_req && !write_lock && pll_lock
                        && (i_cfg_reg_num == REG_PLL);
    wire wr_ok        = i_cfg_wr_req && !write_lock;
    wire wr_lock_hdr  = wr_ok && (i_cfg_reg_num == REG_LOCK_HDR);
    wire wr_node_addr = wr_ok && (i_cfg_reg_num == REG_NODE_ADDR);
    wire wr_pll       = wr_ok && !pll_lock && (i_cfg_reg_num == REG_PLL);
    wire wr_sw_ratio  = wr_ok && (i_cfg_reg_num == REG_SWITCH_RATIO);
    wire wr_ref_ratio = wr_ok && (i_cfg_reg_num == REG_REF_RATIO);
    wire wr_route_lo  = wr_ok && (i_cfg_reg_num == REG_ROUTE_LOW);
    wire wr_route_hi  = wr_ok && (i_cfg_reg_num == REG_ROUTE_HIGH);
    wire wr_dbg_line  = wr_ok && (i_cfg_reg_num == REG_DEBUG_LINE);
    wire wr_origin    = wr_ok && (i_cfg_reg_num == REG_DEBUG_ORIGIN);

    // read words, reserved bits forced to zero
    wire [31:0] ident_word = {CHIP_ID, 6'h00, boot_mode, REVISION, VERSION};
    wire [31:0] descr_word = {8'h00, LINK_COUNT, CORE_COUNT, LINKS_PER_CORE};
    wire [31:0] lock_word  = {write_lock, 22'h000000, pll_lock, 7'h00, header_mode};
    wire [31:0] addr_word  = {16'h0000, node_addr};
    wire [31:0] sw_word    = {16'h0000, switch_ratio};
    wire [31:0] ref_word   = {16'h0000, ref_ratio};
    wire [31:0] dbg_word   = {30'h00000000, call_enable, pull_enable};
    wire [31:0] orig_word  = {27'h0000000, origin_pin, 3'h0, origin_tile};

    // unmapped register numbers read as zero
    wire [31:0] next_rdata =
        (i_cfg_reg_num == REG_IDENT)        ? ident_word   :
        (i_cfg_reg_num == REG_DESCR)        ? descr_word   :
        (i_cfg_reg_num == REG_LOCK_HDR)     ? lock_word    :
        (i_cfg_reg_num == REG_NODE_ADDR)    ? addr_word    :
        (i_cfg_reg_num == REG_PLL)          ? pll_settings :
        (i_cfg_reg_num == REG_SWITCH_RATIO) ? sw_word      :
        (i_cfg_reg_num == REG_REF_RATIO)    ? ref_word     :
        (i_cfg_reg_num == REG_ROUTE_LOW)    ? route_low    :
        (i_cfg_reg_num == REG_ROUTE_HIGH)   ? route_high   :
        (i_cfg_reg_num == REG_DEBUG_LINE)   ? dbg_word     :
        (i_cfg_reg_num == REG_DEBUG_ORIGIN) ? orig_word    : 32'h00000000;

    // pll start value selected by the captured boot pins
    wire [31:0] pll_start =
        (boot_sync == 2'h0) ? PLL_RESET_BOOT_SELECT_PIN_A :
        (boot_sync == 2'h1) ? PLL_RESET_BOOT_SELECT_PIN_B :
        (boot_sync == 2'h2) ? PLL_RESET_MODE2 : PLL_RESET_MODE3;

    // configuration port answer, one cycle after the request
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            o_cfg_wr_done    <= 1'b0;
            o_cfg_wr_refused <= 1'b0;
            o_cfg_rd_done    <= 1'b0;
            o_cfg_rdata      <= 32'h00000000;
        end
        else
        begin
            o_cfg_wr_done    <= i_cfg_wr_req;
            o_cfg_wr_refused <= wr_blocked || wr_pll_block;
            o_cfg_rd_done    <= i_cfg_rd_req;
            o_cfg_rdata      <= i_cfg_rd_req ? next_rdata : o_cfg_rdata;
        end
    end

    // lock, header mode and node address
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            write_lock  <= LOCK_HDR_RESET[LOCK_WRITE_BIT];
            pll_lock    <= LOCK_HDR_RESET[LOCK_PLL_BIT];
            header_mode <= LOCK_HDR_RESET[HEADER_MODE_BIT];
            node_addr   <= NODE_ADDR_RESET;
        end
        else
        begin
            if (wr_lock_hdr)
            begin
                write_lock  <= i_cfg_wdata[LOCK_WRITE_BIT];
                pll_lock    <= i_cfg_wdata[LOCK_PLL_BIT];
                header_mode <= i_cfg_wdata[HEADER_MODE_BIT];
            end
            if (wr_node_addr)
                node_addr <= i_cfg_wdata[NODE_ADDR_W-1:0];
        end
    end

    // pll settings; the start value is loaded once the pins are sampled
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            pll_settings  <= PLL_RESET_BOOT_SELECT_PIN_A;
            boot_mode     <= BOOT_MODE_RESET;
            boot_captured <= 1'b0;
        end
        else if (!boot_captured)
        begin
            pll_settings  <= pll_start;
            boot_mode     <= boot_sync;
            boot_captured <= 1'b1;
        end
        else if (wr_pll)
            pll_settings <= i_cfg_wdata & PLL_WRITE_MASK;
    end

    // tile reset follows only accepted pll writes
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
            o_tile_reset <= 1'b0;
        else
            o_tile_reset <= wr_pll && boot_captured;
    end

    // clock ratios and direction tables
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            switch_ratio <= SWITCH_RATIO_RESET;
            ref_ratio    <= REF_RATIO_RESET;
            route_low    <= ROUTE_RESET;
            route_high   <= ROUTE_RESET;
        end
        else
        begin
            if (wr_sw_ratio)
                switch_ratio <= i_cfg_wdata[RATIO_W-1:0];
            if (wr_ref_ratio)
                ref_ratio <= i_cfg_wdata[RATIO_W-1:0];
            if (wr_route_lo)
                route_low <= i_cfg_wdata;
            if (wr_route_hi)
                route_high <= i_cfg_wdata;
        end
    end

    // boot pins and debug line come from outside: two stages first
    always_ff @(posedge i_ref_clk)
    begin
        boot_meta <= {i_boot_select_pin_b, i_boot_select_pin_a};
        boot_sync <= boot_meta;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            dbg_meta <= 1'b1;
            dbg_sync <= 1'b1;
            dbg_prev <= 1'b1;
        end
        else
        begin
            dbg_meta <= i_debug_line;
            dbg_sync <= dbg_meta;
            dbg_prev <= dbg_sync;
        end
    end

    // activity on the active-low line is a falling edge
    wire dbg_fall = dbg_prev && !dbg_sync;
    wire pin_event = dbg_fall && call_enable;

    // debug line control, call and event origin
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            call_enable       <= DEBUG_LINE_RESET[DBG_CALL_EN_BIT];
            pull_enable       <= DEBUG_LINE_RESET[DBG_PULL_EN_BIT];
            o_core_debug_call <= 1'b0;
            o_debug_line_oe   <= 1'b0;
        end
        else
        begin
            if (wr_dbg_line)
            begin
                call_enable <= i_cfg_wdata[DBG_CALL_EN_BIT];
                pull_enable <= i_cfg_wdata[DBG_PULL_EN_BIT];
            end
            o_core_debug_call <= pin_event;
            o_debug_line_oe   <= pull_enable && i_core_in_debug;
        end
    end

    // a new event beats a software write in the same cycle
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            origin_pin  <= ORIGIN_RESET[1];
            origin_tile <= ORIGIN_RESET[0];
        end
        else if (pin_event || i_tile_debug_event)
        begin
            origin_pin  <= pin_event;
            origin_tile <= i_tile_debug_event;
        end
        else if (wr_origin)
        begin
            origin_pin  <= i_cfg_wdata[ORIGIN_PIN_BIT];
            origin_tile <= i_cfg_wdata[ORIGIN_TILE_BIT];
        end
    end

    // routing lookup: highest differing bit picks the table nibble
    function automatic logic [DIR_IDX_W-1:0] top_mismatch(input logic [NODE_ADDR_W-1:0] diff);
        logic [DIR_IDX_W-1:0] idx;
        idx = '0;
        for (int b = 0; b < NODE_ADDR_W; b++)
            if (diff[b])
                idx = DIR_IDX_W'(b);
        return idx;
    endfunction : top_mismatch

    wire [NODE_ADDR_W-1:0] dest_diff  = i_route_dest ^ node_addr;
    wire                   dest_match = (dest_diff == '0);
    wire [DIR_IDX_W-1:0]   dir_index  = top_mismatch(dest_diff);
    wire [63:0]            route_all  = {route_high, route_low};
    wire [DIR_W-1:0]       dir_pick   = route_all[{dir_index, 2'b00} +: DIR_W];

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            o_route_valid     <= 1'b0;
            o_route_local     <= 1'b0;
            o_route_direction <= '0;
        end
        else
        begin
            o_route_valid <= i_route_req;
            if (i_route_req)
            begin
                o_route_local     <= dest_match;
                o_route_direction <= dest_match ? '0 : dir_pick;
            end
        end
    end

    // clock ratio tick generators
    ratio_tick_divider #(
        .RATIO_W (RATIO_W)
    ) u_switch_div (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_ratio   (switch_ratio),
        .o_tick    (o_switch_clk_tick)
    );

    ratio_tick_divider #(
        .RATIO_W (RATIO_W)
    ) u_ref_div (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_ratio   (ref_ratio),
        .o_tick    (o_ref_clk_tick)
    );

    // settings outputs straight from registers
    assign o_one_byte_header    = header_mode;
    assign o_node_addr          = node_addr;
    assign o_pll_output_divider = pll_settings[PLL_OD_LSB +: PLL_OD_W];
    assign o_pll_feedback_mult  = pll_settings[PLL_F_LSB +: PLL_F_W];
    assign o_pll_input_divider  = pll_settings[PLL_R_LSB +: PLL_R_W];
    // open drain: only ever pulls low
    assign o_debug_line_out     = 1'b0;

endmodule : switch_node_config_regs
